// *** logic/ets_pkg.sv ***
package ets_pkg;
  // Timebase: the phase timers count whole milliseconds.
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRESC_W = 16;

  // Phase durations in milliseconds.
  localparam int unsigned DETECT_MS = 1;
  localparam int unsigned TABLE_MS = 10;
  localparam int unsigned DISCH_MS = 20;
  localparam int unsigned ANALOG_MS = 50;
  localparam int unsigned JUDGE_MS = 15;
  localparam int unsigned MS_W = 14;
  localparam logic [MS_W-1:0] DELAY_MAX_MS = 14'h270F;
  localparam logic [MS_W-1:0] MS_ONE = 14'h0001;

  // Register map, byte addresses.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DELAY = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h10;

  // Field layout.
  localparam int unsigned CTRL_SINK_BIT = 0;
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_ANALOG = 1;
  localparam int unsigned EV_ABORT = 2;
  localparam int unsigned EV_IGNORED = 3;
  localparam int unsigned STATE_FSM_LSB = 0;
  localparam int unsigned STATE_BUSY_BIT = 8;
  localparam int unsigned STATE_TBL_LSB = 16;
  localparam int unsigned TBL_W = 8;
  localparam int unsigned SYNC_N = TBL_W + 2;

  // Reset values.
  localparam logic SINK_RST = 1'h0;
  localparam logic [MS_W-1:0] DELAY_RST = 14'h0000;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  localparam logic [TBL_W-1:0] TBL_NONE = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DETECT, ST_TABLE, ST_DISCH, ST_DELAY, ST_ANALOG, ST_JUDGE, ST_FINISH
  } ets_state_t;
endpackage : ets_pkg

// *** logic/ets_sequencer.sv ***
`timescale 1ns/1ns
module ets_sequencer #(
  parameter int unsigned CYC_PER_MS = ets_pkg::CYC_PER_MS,
  parameter int unsigned JUDGE_W = 9
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ets_pkg::ADDR_W-1:0] addr,
  input wire logic [ets_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [ets_pkg::DATA_W-1:0] rd_data,
  output logic irq,
  input wire logic start_pin,
  input wire logic stop_pin,
  input wire logic [ets_pkg::TBL_W-1:0] table_select_lines,
  input wire logic volt_lower,
  input wire logic [JUDGE_W-1:0] judge_result,
  output logic [ets_pkg::TBL_W-1:0] table_num,
  output logic table_load,
  output logic test_finished_flag,
  output logic analog_done_pin,
  output logic [JUDGE_W-1:0] judge_pins
);
  import ets_pkg::*;

  if (CYC_PER_MS < 2 || CYC_PER_MS >= (1 << PRESC_W) || JUDGE_W < 1) begin : g_bad_param
    $error("ets_sequencer: unsupported parameter value");
  end

  // Pin synchronisers; a level counts once the second and third stages agree.
  wire [SYNC_N-1:0] raw = {stop_pin, start_pin, table_select_lines};
  logic [SYNC_N-1:0] s1_q, s2_q, s3_q, filt_q;
  genvar gi;
  for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        s1_q[gi] <= 1'h0;
        s2_q[gi] <= 1'h0;
        s3_q[gi] <= 1'h0;
        filt_q[gi] <= 1'h0;
      end else begin
        s1_q[gi] <= raw[gi];
        s2_q[gi] <= s1_q[gi];
        s3_q[gi] <= s2_q[gi];
        if (s2_q[gi] == s3_q[gi]) begin
          filt_q[gi] <= s3_q[gi];
        end
      end
    end
  end

  // Registers.
  logic sink_q, sink_d;
  logic [MS_W-1:0] delay_q, delay_d;
  logic [EV_W-1:0] status_q, status_d, mask_q, mask_d, ev;
  logic [DATA_W-1:0] rd_data_q, rd_data_d;
  logic irq_q;
  ets_state_t state_q, state_d;
  logic [MS_W-1:0] ms_left_q, ms_left_d, load_ms;
  logic [PRESC_W-1:0] presc_q, presc_d;
  logic start_prev_q, stop_prev_q;
  logic [TBL_W-1:0] table_num_q, table_num_d;
  logic table_load_q;
  logic fin_q, fin_d, adone_q, adone_d;
  logic [JUDGE_W-1:0] judge_q, judge_d;
  logic fin_pin_q, adone_pin_q;
  logic [JUDGE_W-1:0] judge_pin_q;

  // Logical contact state: sinking setting sees inverted terminal levels.
  wire [SYNC_N-1:0] logical = filt_q ^ {SYNC_N{sink_q}};
  wire [TBL_W-1:0] tbl_log = logical[TBL_W-1:0];
  wire start_log = logical[TBL_W];
  wire stop_log = logical[TBL_W+1];
  wire start_edge = start_log && !start_prev_q;
  wire stop_edge = stop_log && !stop_prev_q;
  wire busy = (state_q != ST_IDLE);
  wire tick = (presc_q == PRESC_W'(CYC_PER_MS - 1));
  wire phase_end = (ms_left_q == '0);

  // Register decode.
  wire sel_ctrl = (addr == REG_CTRL);
  wire sel_delay = (addr == REG_DELAY);
  wire sel_status = (addr == REG_STATUS);
  wire sel_mask = (addr == REG_MASK);
  wire sel_state = (addr == REG_STATE);
  wire rd_status = rd_en && sel_status;
  wire [MS_W-1:0] wr_delay = wr_data[MS_W-1:0];
  assign sink_d = (wr_en && sel_ctrl) ? wr_data[CTRL_SINK_BIT] : sink_q;
  // Delay writes are cut to their low 14 bits; values above the documented maximum then saturate at it.
  assign delay_d = !(wr_en && sel_delay) ? delay_q :
                   (wr_delay > DELAY_MAX_MS) ? DELAY_MAX_MS : wr_delay;
  assign mask_d = (wr_en && sel_mask) ? wr_data[EV_W-1:0] : mask_q;
  // A new event wins over the clear by a status read in the same cycle.
  assign status_d = (rd_status ? '0 : status_q) | ev;
  wire [DATA_W-1:0] state_word = (DATA_W'(state_q) << STATE_FSM_LSB)
                               | (DATA_W'(busy) << STATE_BUSY_BIT)
                               | (DATA_W'(table_num_q) << STATE_TBL_LSB);
  assign rd_data_d = !rd_en ? '0 :
                     sel_ctrl ? DATA_W'(sink_q) << CTRL_SINK_BIT :
                     sel_delay ? DATA_W'(delay_q) :
                     sel_status ? DATA_W'(status_q) :
                     sel_mask ? DATA_W'(mask_q) :
                     sel_state ? state_word : '0;

  // Sequencer.
  always_comb begin
    state_d = state_q;
    table_num_d = table_num_q;
    fin_d = fin_q;
    adone_d = adone_q;
    judge_d = judge_q;
    ev = '0;
    case (state_q)
      ST_IDLE: begin
        if (start_edge) begin
          state_d = ST_DETECT;
          table_num_d = tbl_log;
          fin_d = 1'h0;
          adone_d = 1'h0;
        end
      end
      ST_DETECT: begin
        if (phase_end) begin
          state_d = (table_num_q == TBL_NONE) ? ST_DELAY : ST_TABLE;
        end
      end
      ST_TABLE: begin
        if (phase_end) begin
          state_d = volt_lower ? ST_DISCH : ST_DELAY;
        end
      end
      ST_DISCH: begin
        if (phase_end) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (phase_end) begin
          state_d = ST_ANALOG;
        end
      end
      ST_ANALOG: begin
        if (phase_end) begin
          state_d = ST_JUDGE;
          adone_d = 1'h1;
          ev[EV_ANALOG] = 1'h1;
        end
      end
      ST_JUDGE: begin
        if (phase_end) begin
          state_d = ST_FINISH;
          judge_d = judge_result;
        end
      end
      ST_FINISH: begin
        state_d = ST_IDLE;
        fin_d = 1'h1;
        ev[EV_DONE] = 1'h1;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (busy && start_edge) begin
      ev[EV_IGNORED] = 1'h1;
    end
    if (busy && stop_edge && state_q != ST_FINISH) begin
      state_d = ST_IDLE;
      fin_d = 1'h1;
      ev[EV_ABORT] = 1'h1;
    end
  end

  always_comb begin
    case (state_d)
      ST_DETECT: load_ms = MS_W'(DETECT_MS);
      ST_TABLE: load_ms = MS_W'(TABLE_MS);
      ST_DISCH: load_ms = MS_W'(DISCH_MS);
      ST_DELAY: load_ms = delay_q;
      ST_ANALOG: load_ms = MS_W'(ANALOG_MS);
      ST_JUDGE: load_ms = MS_W'(JUDGE_MS);
      default: load_ms = '0;
    endcase
  end

  // Each phase restarts the millisecond prescaler so its length is exact.
  wire phase_change = (state_d != state_q);
  assign presc_d = (phase_change || tick) ? '0 : presc_q + PRESC_W'(1);
  assign ms_left_d = phase_change ? load_ms :
                     (tick && !phase_end) ? ms_left_q - MS_ONE : ms_left_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sink_q <= SINK_RST;
      delay_q <= DELAY_RST;
      mask_q <= MASK_RST;
      status_q <= '0;
      rd_data_q <= '0;
      irq_q <= 1'h0;
    end else begin
      sink_q <= sink_d;
      delay_q <= delay_d;
      mask_q <= mask_d;
      status_q <= status_d;
      rd_data_q <= rd_data_d;
      irq_q <= |(status_d & mask_d);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      ms_left_q <= '0;
      presc_q <= '0;
      start_prev_q <= 1'h0;
      stop_prev_q <= 1'h0;
      table_num_q <= TBL_NONE;
      table_load_q <= 1'h0;
      fin_q <= 1'h1;
      adone_q <= 1'h0;
      judge_q <= '0;
    end else begin
      state_q <= state_d;
      ms_left_q <= ms_left_d;
      presc_q <= presc_d;
      start_prev_q <= start_log;
      stop_prev_q <= stop_log;
      table_num_q <= table_num_d;
      table_load_q <= (state_d == ST_TABLE) && (state_q != ST_TABLE);
      fin_q <= fin_d;
      adone_q <= adone_d;
      judge_q <= judge_d;
    end
  end

  // Terminal levels follow the logic in sourcing and are inverted in sinking.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fin_pin_q <= 1'h1;
      adone_pin_q <= 1'h0;
      judge_pin_q <= '0;
    end else begin
      fin_pin_q <= fin_d ^ sink_d;
      adone_pin_q <= adone_d ^ sink_d;
      judge_pin_q <= judge_d ^ {JUDGE_W{sink_d}};
    end
  end

  assign rd_data = rd_data_q;
  assign irq = irq_q;
  assign table_num = table_num_q;
  assign table_load = table_load_q;
  assign test_finished_flag = fin_pin_q;
  assign analog_done_pin = adone_pin_q;
  assign judge_pins = judge_pin_q;

  a_edge_only: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_IDLE && !start_edge) |=> (state_q == ST_IDLE))
    else $error("test started without a start edge");
  a_busy_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    (busy && start_edge) |=> ($stable(table_num_q) && state_q != ST_DETECT))
    else $error("start accepted during a test");
  a_table_sample: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_IDLE && start_edge) |=> (state_q == ST_DETECT && table_num_q == $past(tbl_log)))
    else $error("table lines not sampled at start");
  a_detect_done: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_DETECT && phase_end && !stop_edge) |=>
      (state_q == (table_num_q == TBL_NONE ? ST_DELAY : ST_TABLE)))
    else $error("detection phase did not advance correctly");
  a_disch_wait: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_TABLE && phase_end && volt_lower && !stop_edge) |=>
      (state_q == ST_DISCH && ms_left_q == MS_W'(DISCH_MS)))
    else $error("discharge wait missing");
  a_analog_len: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_DELAY && phase_end && !stop_edge) |=>
      (state_q == ST_ANALOG && ms_left_q == MS_W'(ANALOG_MS)))
    else $error("analog phase not loaded with its duration");
  a_analog_flag: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_ANALOG && phase_end && !stop_edge) |=>
      (adone_q && state_q == ST_JUDGE && ms_left_q == MS_W'(JUDGE_MS)))
    else $error("analog-done flag or judgment phase missing");
  a_judge_first: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_JUDGE && phase_end && !stop_edge) |=>
      (judge_q == $past(judge_result) && !fin_q) ##1 fin_q)
    else $error("finished flag before judgment outputs");
  a_stop_abort: assert property (@(posedge clk) disable iff (!reset_n)
    (busy && stop_edge) |=> (state_q == ST_IDLE && fin_q))
    else $error("stop edge did not abort the test");
  a_pin_level: assert property (@(posedge clk) disable iff (!reset_n)
    (test_finished_flag == ((state_q == ST_IDLE) ^ sink_q))
      && (analog_done_pin == (adone_q ^ sink_q)))
    else $error("terminal level does not match polarity setting");
  a_sequence: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_DELAY) |=> (state_q inside {ST_DELAY, ST_ANALOG, ST_IDLE}))
    else $error("delay phase left out of order");
endmodule : ets_sequencer

// *** tb/ets_ctrl_model.sv ***
`timescale 1ns/1ns
module ets_ctrl_model
  import ets_pkg::*;
(
  input wire logic clk,
  input wire logic sink,
  output logic start_pin,
  output logic stop_pin,
  output logic [ets_pkg::TBL_W-1:0] table_select_lines
);
  logic start_l = 1'b0;
  logic stop_l = 1'b0;
  logic [TBL_W-1:0] tbl_l = 8'h00;
  // Contacts are modelled in logical terms; the terminal level flips in the sinking setting.
  assign start_pin = start_l ^ sink;
  assign stop_pin = stop_l ^ sink;
  assign table_select_lines = tbl_l ^ {TBL_W{sink}};
  // A contact is closed for hold cycles; the bench passes at least one millisecond.
  task automatic press(input logic is_stop, input logic [TBL_W-1:0] tbl, input int hold);
    @(posedge clk);
    tbl_l <= tbl;
    start_l <= ~is_stop;
    stop_l <= is_stop;
    repeat (hold) @(posedge clk);
    start_l <= 1'b0;
    stop_l <= 1'b0;
  endtask : press
endmodule : ets_ctrl_model

// *** tb/tb_ets_sequencer.sv ***
`timescale 1ns/1ns
module tb_ets_sequencer;
  import ets_pkg::*;
  localparam int CPM = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic sink = 1'b0;
  logic volt_lower = 1'b0;
  logic [8:0] judge_result = 9'h000;
  logic [DATA_W-1:0] rd_data;
  logic [8:0] judge_pins;
  logic [TBL_W-1:0] table_select_lines, table_num;
  logic irq, start_pin, stop_pin, table_load, test_finished_flag, analog_done_pin;
  int miscompares = 0;
  int cmp_count = 0;

  always #50 clk = ~clk;

  ets_sequencer #(.CYC_PER_MS(CPM), .JUDGE_W(9)) dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .start_pin(start_pin),
    .stop_pin(stop_pin), .table_select_lines(table_select_lines),
    .volt_lower(volt_lower), .judge_result(judge_result), .table_num(table_num),
    .table_load(table_load), .test_finished_flag(test_finished_flag),
    .analog_done_pin(analog_done_pin), .judge_pins(judge_pins));

  ets_ctrl_model u_ctrl (.clk(clk), .sink(sink), .start_pin(start_pin),
    .stop_pin(stop_pin), .table_select_lines(table_select_lines));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Outputs are looked at just after the edge, once its updates have landed.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, e);
  endtask : rd

  task automatic reset_test();
    check(test_finished_flag, 1'b1);
    rd(REG_CTRL, 32'h0);
    rd(REG_DELAY, 32'h0);
    rd(REG_MASK, 32'h0);
    rd(REG_STATE, 32'h0);
    wr(8'h14, 32'hFFFF);
    rd(8'h14, 32'h0);
    wr(REG_DELAY, 32'hFFFF);
    rd(REG_DELAY, 32'h270F);
  endtask : reset_test

  // One full test; phase lengths are judged from the finished flag's fall.
  task automatic run_test(input logic [7:0] tbl, input logic [13:0] dly, input logic vl,
      input logic [8:0] jr, input int hold, input bit again);
    int n;
    int t_an;
    int loads;
    int exp_an;
    logic [8:0] prev;
    n = 0;
    t_an = 0;
    loads = 0;
    exp_an = (DETECT_MS + ANALOG_MS + dly + (tbl != 0 ? TABLE_MS : 0) + (vl ? DISCH_MS : 0)) * CPM;
    wr(REG_DELAY, {18'h0, dly});
    volt_lower <= vl;
    judge_result <= jr;
    fork
      begin
        u_ctrl.press(1'b0, tbl, hold);
        repeat (100) @(posedge clk);
        if (again) u_ctrl.press(1'b0, tbl, 12);
      end
      begin
        while ((test_finished_flag ^ sink) === 1'b1 && n < 40) begin
          tick();
          n++;
        end
        if (n >= 40) begin
          miscompares++;
          test_done();
        end
        check(n <= CPM, 1'b1);
        check(table_num, tbl);
        n = 0;
        while ((test_finished_flag ^ sink) !== 1'b1 && n < 3000) begin
          prev = judge_pins;
          loads += table_load;
          if (t_an == 0 && (analog_done_pin ^ sink) === 1'b1) t_an = n;
          tick();
          n++;
        end
        if (n >= 3000) begin
          miscompares++;
          test_done();
        end
        check(t_an >= exp_an && t_an <= exp_an + 10, 1'b1);
        check(n >= exp_an + JUDGE_MS * CPM && n <= exp_an + JUDGE_MS * CPM + 14, 1'b1);
        check(prev, jr ^ {9{sink}});
        check(loads, tbl != 0);
        repeat (20) tick();
        check(test_finished_flag ^ sink, 1'b1);
      end
    join
  endtask : run_test

  task automatic abort_test();
    judge_result <= 9'h1FF;
    fork
      u_ctrl.press(1'b0, 8'h01, 12);
      begin
        repeat (300) @(posedge clk);
        rd(REG_STATE, 32'h0001_0103);
        u_ctrl.press(1'b1, 8'h01, 12);
      end
    join
    tick();
    check(test_finished_flag, 1'b1);
    check(judge_pins, 9'h0AA);
    check(irq, 1'b0);
    rd(REG_STATUS, 32'h4);
  endtask : abort_test

  // Flipping polarity may look like a start edge, so the bench waits for idle afterwards.
  task automatic sink_test();
    int n;
    n = 0;
    wr(REG_CTRL, 32'h1);
    sink <= 1'b1;
    repeat (20) tick();
    while (test_finished_flag !== 1'b0 && n < 1500) begin
      tick();
      n++;
    end
    if (n >= 1500) begin
      miscompares++;
      test_done();
    end
    check(test_finished_flag, 1'b0);
    run_test(8'h00, 14'h0000, 1'b0, 9'h133, 800, 1'b0);
  endtask : sink_test

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    reset_test();
    wr(REG_MASK, 32'h1);
    run_test(8'h03, 14'h0002, 1'b0, 9'h155, 12, 1'b1);
    check(irq, 1'b1);
    rd(REG_STATUS, 32'hB);
    tick();
    check(irq, 1'b0);
    run_test(8'h05, 14'h0000, 1'b1, 9'h0AA, 12, 1'b0);
    rd(REG_STATUS, 32'h3);
    abort_test();
    sink_test();
    test_done();
  end
endmodule : tb_ets_sequencer
